// ==== bench/sgl_host_model.sv ====
`timescale 1ns/1ps
module sgl_host_model (
    // Link clock
    input wire logic lclk_i,
    // Serial pins
    output logic serial_clk_o,
    output logic serial_data_o,
    output logic window_n_o
);
    logic run;
    // Clock runs only while run is set: during frames and stray pulses
    assign serial_clk_o = lclk_i & run;
    initial begin
        run = 1'b0;
        serial_data_o = 1'b0;
        window_n_o = 1'b1;
    end
    task automatic frame(input logic [15:0] w, input logic long);
        int n;
        n = long ? 16 : 8;
        @(negedge lclk_i);
        window_n_o <= 1'b0;
        @(negedge lclk_i);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_o <= w[i];
            run <= 1'b1;
            @(negedge lclk_i);
        end
        run <= 1'b0;
        serial_data_o <= ~w[0];
        @(negedge lclk_i);
        window_n_o <= 1'b1;
        @(negedge lclk_i);
    endtask : frame
    // Clock pulses with the window closed, which must be ignored
    task automatic stray();
        @(negedge lclk_i);
        serial_data_o <= ~serial_data_o;
        run <= 1'b1;
        repeat (2) @(negedge lclk_i);
        run <= 1'b0;
    endtask : stray
endmodule : sgl_host_model

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic lclk = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sclk;
    logic serial_gain_in;
    logic win_n;
    logic tx_on = 1'b0;
    logic sleep_n = 1'b1;
    logic [7:0] gain_word;
    logic [15:0] gain_cdb;
    logic gain_update;
    logic tx_en;
    logic sleep_mode;
    logic [31:0] r;
    logic [31:0] sx;
    logic e;
    logic [7:0] w;
    logic [7:0] ew;
    logic [15:0] lw;
    logic [7:0] exp_q[$];
    int seed = 88292;
    int n_mismatch = 0;
    int num_checks = 0;

    always #2 clk_i = ~clk_i;
    initial begin
        #1.3;
        forever #40 lclk = ~lclk;
    end

    sgl_host_model host (.lclk_i(lclk), .serial_clk_o(sclk), .serial_data_o(serial_gain_in),
        .window_n_o(win_n));

    sgl_serial_gain_loader uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
        .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .serial_clk_i(sclk), .serial_gain_in_i(serial_gain_in), .load_window_n_i(win_n),
        .transmit_on_i(tx_on), .sleep_n_i(sleep_n), .gain_word_o(gain_word),
        .gain_cdb_o(gain_cdb), .gain_update_o(gain_update),
        .transmit_enable_o(tx_en), .sleep_mode_o(sleep_mode));

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        num_checks++;
        if (got !== ex) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] wd);
        int t;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (t >= 50) chk("pready", 32'h1, 32'h0);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [15:0] exp_cdb(input logic [7:0] v);
        logic [15:0] tbl [9];
        int s;
        tbl = '{16'hF8E8, 16'hFB42, 16'hFD9C, 16'hFFF6, 16'h0250, 16'h04AA, 16'h0704, 16'h095E,
            16'h0BB8};
        s = 0;
        for (int i = 0; i < 8; i++) if (v[i]) s = i + 1;
        return tbl[s];
    endfunction : exp_cdb

    always @(negedge clk_i) begin
        if (gain_update === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected_update", 32'h0, 32'h1);
            end else begin
                ew = exp_q.pop_front();
                chk("gain_word", {24'h0, ew}, {24'h0, gain_word});
                @(negedge clk_i);
                chk("gain_cdb", {16'h0, exp_cdb(ew)}, {16'h0, gain_cdb});
            end
        end
    end

    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        apb(sgl_pkg::OFS_CTRL, 1'b0, 32'h0);
        chk("ctrl_rst", sgl_pkg::CTRL_RST, r);
        apb(12'h010, 1'b0, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, e});
        $display("test registers done");
        for (int k = 0; k < 8; k++) begin
            w = (k == 0) ? 8'h00 : (k == 1) ? 8'h80 : 8'($random(seed));
            exp_q.push_back(w);
            host.frame({8'h00, w}, 1'b0);
            repeat (8) @(posedge clk_i);
        end
        $display("test words done");
        lw = 16'($random(seed));
        exp_q.push_back(lw[7:0]);
        host.frame(lw, 1'b1);
        host.stray();
        repeat (8) @(posedge clk_i);
        apb(sgl_pkg::OFS_SHIFT, 1'b0, 32'h0);
        chk("shift", {16'h0, lw[7:0], lw[7:0]}, r);
        $display("test long frame done");
        apb(sgl_pkg::OFS_CTRL, 1'b1, 32'h0);
        apb(sgl_pkg::OFS_CTRL, 1'b0, 32'h0);
        chk("ctrl_wr", 32'h0, r);
        host.frame(~lw, 1'b0);
        repeat (8) @(posedge clk_i);
        chk("held_gain", {24'h0, lw[7:0]}, {24'h0, gain_word});
        apb(sgl_pkg::OFS_CTRL, 1'b1, 32'h1);
        w = 8'($random(seed));
        exp_q.push_back(w);
        host.frame({8'h00, w}, 1'b0);
        repeat (8) @(posedge clk_i);
        $display("test hold done");
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_i);
            tx_on <= m[0];
            sleep_n <= m[1];
            repeat (5) @(posedge clk_i);
            @(negedge clk_i);
            chk("tx_en", {31'h0, m[0]}, {31'h0, tx_en});
            chk("sleep", {31'h0, ~m[1]}, {31'h0, sleep_mode});
        end
        apb(sgl_pkg::OFS_GAIN, 1'b0, 32'h0);
        chk("gain_reg", {16'h0, exp_cdb(w)}, r);
        sx = (32'h8 << sgl_pkg::STAT_CNT_LSB) | (32'h1 << sgl_pkg::STAT_TX_BIT);
        sx = sx | (32'h1 << sgl_pkg::STAT_WIN_BIT) | {24'h0, w};
        apb(sgl_pkg::OFS_STATUS, 1'b0, 32'h0);
        chk("status", sx, r);
        $display("test levels done");
        chk("queue_left", 32'h0, 32'(exp_q.size()));
        give_verdict();
    end
endmodule : tb_top

// ==== hdl/sgl_gain_map.sv ====
`timescale 1ns/1ps
module sgl_gain_map (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Applied gain word
    input wire logic [7:0] word_i,
    // Gain in hundredths of a dB, two's complement
    output logic [15:0] gain_cdb_o
);

    // Step index: position of the highest set bit plus one, zero for code 0
    function automatic logic [3:0] step_of(input logic [7:0] w);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 0; i < 8; i++) begin
            if (w[i]) begin
                s = 4'(i + 1);
            end
        end
        return s;
    endfunction : step_of

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gain_cdb_o <= sgl_pkg::GAIN_BASE_CDB;
        end else begin
            gain_cdb_o <= 16'(sgl_pkg::GAIN_BASE_CDB
                + 16'(16'(step_of(word_i)) * sgl_pkg::GAIN_STEP_CDB));
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    top_code_a: assert property (word_i == 8'h80 |=> gain_cdb_o == sgl_pkg::GAIN_TOP_CDB)
        else $error("Code 128 does not give full gain");

    zero_code_a: assert property (word_i == 8'h00 |=> gain_cdb_o == sgl_pkg::GAIN_BASE_CDB)
        else $error("Code 0 does not give base gain");

endmodule : sgl_gain_map

// ==== hdl/sgl_pkg.sv ====
package sgl_pkg;

    // Word and bus widths
    localparam int WORD_W = 8;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int SYNC_STAGES = 2;

    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_SHIFT = 12'h008;
    localparam logic [11:0] OFS_GAIN = 12'h00C;

    // Control fields and reset value
    localparam int CTRL_LOAD_EN_BIT = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;

    // Status fields
    localparam int STAT_WORD_LSB = 0;
    localparam int STAT_WIN_BIT = 8;
    localparam int STAT_TX_BIT = 9;
    localparam int STAT_SLEEP_BIT = 10;
    localparam int STAT_SHIFTING_BIT = 11;
    localparam int STAT_CNT_LSB = 12;

    // Shift register fields
    localparam int SHIFT_SLAVE_LSB = 8;

    // Reset value of datapath state and bit count limit
    localparam logic [7:0] GAIN_WORD_RST = 8'h00;
    localparam logic [3:0] BIT_CNT_MAX = 4'h8;

    // Gain map in hundredths of a dB: -18.16 dB base, 6.02 dB per step
    localparam logic [15:0] GAIN_BASE_CDB = 16'hF8E8;
    localparam logic [15:0] GAIN_STEP_CDB = 16'h025A;
    localparam logic [15:0] GAIN_TOP_CDB = 16'h0BB8;

    // Pins from the host, as one carrier
    typedef struct packed {
        logic serial_clk;
        logic serial_data;
        logic window_n;
        logic tx_on;
        logic sleep_n;
    } sgl_pins_t;

    // Load window state
    typedef enum logic [1:0] {
        SGL_HOLD = 2'b01,
        SGL_SHIFT = 2'b10
    } sgl_state_t;

endpackage : sgl_pkg

// ==== hdl/sgl_serial_gain_loader.sv ====
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - Gain arrives as an 8-bit serial word on serial_gain_in, MSB first.
// - Serial word held in an 8-bit master-slave register clocked by the serial clock.
// - Rising serial clock captures into master; following falling edge moves into slave.
// - Window rising applies shifted word to gain and stops further shifting.
// - Window falling holds previous gain and opens the shift register for loading.
// - Transmission disabled while transmit_on is low, enabled while high.
// - Sleep input low selects low-power sleep; high gives normal operation.
// - Gain code maps to -18.16 dB plus 6.02 dB per major carry.
// - Serial clock edges act only after the window's falling edge.
module sgl_serial_gain_loader (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // APB slave
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Serial link and level pins
    input wire logic serial_clk_i,
    input wire logic serial_gain_in_i,
    input wire logic load_window_n_i,
    input wire logic transmit_on_i,
    input wire logic sleep_n_i,
    // Attenuator core and power control
    output logic [7:0] gain_word_o,
    output logic [15:0] gain_cdb_o,
    output logic gain_update_o,
    output logic transmit_enable_o,
    output logic sleep_mode_o
);

    sgl_pkg::sgl_pins_t pins_raw;
    sgl_pkg::sgl_pins_t pins_s;
    logic [$bits(sgl_pkg::sgl_pins_t)-1:0] pins_sync;
    logic sclk_d;
    logic win_d;
    logic sclk_rise;
    logic sclk_fall;
    logic win_rise;
    logic win_fall;
    sgl_pkg::sgl_state_t state;
    logic [7:0] master;
    logic [7:0] slave;
    logic [3:0] bit_cnt;
    logic load_en;
    logic shifting;
    logic apb_setup;
    logic apb_write;
    logic [31:0] next_rdata;
    logic next_err;

    // Pins pass two flip-flops as one group, keeping their relative order
    assign pins_raw = '{
        serial_clk: serial_clk_i,
        serial_data: serial_gain_in_i,
        window_n: load_window_n_i,
        tx_on: transmit_on_i,
        sleep_n: sleep_n_i
    };

    sgl_sync #(
        .W($bits(sgl_pkg::sgl_pins_t))
    ) u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i(pins_raw),
        .q_o(pins_sync)
    );

    assign pins_s = sgl_pkg::sgl_pins_t'(pins_sync);

    // Edge history of the serial clock and the load window
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // Same level as the synchroniser after reset: no false window fall
            sclk_d <= 1'b0;
            win_d <= 1'b0;
        end else begin
            sclk_d <= pins_s.serial_clk;
            win_d <= pins_s.window_n;
        end
    end

    assign sclk_rise = pins_s.serial_clk & ~sclk_d;
    assign sclk_fall = ~pins_s.serial_clk & sclk_d;
    assign win_rise = pins_s.window_n & ~win_d;
    assign win_fall = ~pins_s.window_n & win_d;
    assign shifting = (state == sgl_pkg::SGL_SHIFT) & load_en;

    // Load window state machine
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= sgl_pkg::SGL_HOLD;
        end else begin
            case (state)
                sgl_pkg::SGL_HOLD: begin
                    if (win_fall) begin
                        state <= sgl_pkg::SGL_SHIFT;
                    end
                end
                sgl_pkg::SGL_SHIFT: begin
                    if (win_rise) begin
                        state <= sgl_pkg::SGL_HOLD;
                    end
                end
                default: begin
                    state <= sgl_pkg::SGL_HOLD;
                end
            endcase
        end
    end

    // Master stage: shift in on the rising serial clock, MSB first
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            master <= sgl_pkg::GAIN_WORD_RST;
        end else if (shifting && sclk_rise) begin
            master <= {slave[6:0], pins_s.serial_data};
        end
    end

    // Slave stage: take the master on the falling serial clock
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            slave <= sgl_pkg::GAIN_WORD_RST;
        end else if (shifting && sclk_fall) begin
            slave <= master;
        end
    end

    // Bits seen in the current window, saturating
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bit_cnt <= 4'h0;
        end else if (win_fall) begin
            bit_cnt <= 4'h0;
        end else if (shifting && sclk_rise && bit_cnt != sgl_pkg::BIT_CNT_MAX) begin
            bit_cnt <= 4'(bit_cnt + 4'h1);
        end
    end

    // Output latch: updated only on the window's rising edge
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gain_word_o <= sgl_pkg::GAIN_WORD_RST;
            gain_update_o <= 1'b0;
        end else begin
            gain_update_o <= 1'b0;
            if (state == sgl_pkg::SGL_SHIFT && win_rise && load_en) begin
                gain_word_o <= master;
                gain_update_o <= 1'b1;
            end
        end
    end

    sgl_gain_map u_gain_map (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .word_i(gain_word_o),
        .gain_cdb_o(gain_cdb_o)
    );

    // Transmit enable and sleep levels
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            transmit_enable_o <= 1'b0;
            sleep_mode_o <= 1'b0;
        end else begin
            transmit_enable_o <= pins_s.tx_on;
            sleep_mode_o <= ~pins_s.sleep_n;
        end
    end

    // APB: no wait states, answer in the first access cycle
    assign apb_setup = psel_i & ~penable_i;
    assign apb_write = psel_i & penable_i & pready_o & pwrite_i;

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        if (paddr_i == sgl_pkg::OFS_CTRL) begin
            next_rdata[sgl_pkg::CTRL_LOAD_EN_BIT] = load_en;
        end else if (paddr_i == sgl_pkg::OFS_STATUS) begin
            next_rdata[sgl_pkg::STAT_WORD_LSB +: 8] = gain_word_o;
            next_rdata[sgl_pkg::STAT_WIN_BIT] = pins_s.window_n;
            next_rdata[sgl_pkg::STAT_TX_BIT] = transmit_enable_o;
            next_rdata[sgl_pkg::STAT_SLEEP_BIT] = sleep_mode_o;
            next_rdata[sgl_pkg::STAT_SHIFTING_BIT] = shifting;
            next_rdata[sgl_pkg::STAT_CNT_LSB +: 4] = bit_cnt;
        end else if (paddr_i == sgl_pkg::OFS_SHIFT) begin
            next_rdata[7:0] = master;
            next_rdata[sgl_pkg::SHIFT_SLAVE_LSB +: 8] = slave;
        end else if (paddr_i == sgl_pkg::OFS_GAIN) begin
            next_rdata[15:0] = gain_cdb_o;
        end else begin
            next_err = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= apb_setup;
            pslverr_o <= apb_setup & next_err;
            if (apb_setup && !pwrite_i) begin
                prdata_o <= next_rdata;
            end else begin
                prdata_o <= 32'h0000_0000;
            end
        end
    end

    // Control register: load enable gates the whole serial path
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            load_en <= sgl_pkg::CTRL_RST[sgl_pkg::CTRL_LOAD_EN_BIT];
        end else if (apb_write && paddr_i == sgl_pkg::OFS_CTRL && pstrb_i[0]) begin
            load_en <= pwdata_i[sgl_pkg::CTRL_LOAD_EN_BIT];
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_open_window;
        win_fall ##1 (state == sgl_pkg::SGL_SHIFT);
    endsequence

    sequence s_close_window;
        (state == sgl_pkg::SGL_SHIFT) && win_rise && load_en;
    endsequence

    shift_msb_a: assert property (shifting && sclk_rise |=>
        master == {$past(slave[6:0]), $past(pins_s.serial_data)})
        else $error("Master did not shift MSB first");

    slave_move_a: assert property (shifting && sclk_fall |=> slave == $past(master))
        else $error("Slave did not take master on falling clock");

    master_steady_a: assert property (!sclk_rise |=> $stable(master))
        else $error("Master changed without a rising serial clock");

    word_apply_a: assert property (s_close_window |=>
        gain_word_o == $past(master) && gain_update_o)
        else $error("Window rise did not apply the shifted word");

    shift_stop_a: assert property (state == sgl_pkg::SGL_HOLD |=> $stable(master))
        else $error("Shifting outside the load window");

    gain_hold_a: assert property (!win_rise |=> $stable(gain_word_o))
        else $error("Gain changed outside a window rise");

    window_open_a: assert property (win_fall && state == sgl_pkg::SGL_HOLD |->
        s_open_window)
        else $error("Window fall did not open shifting");

    tx_follow_a: assert property (##1 transmit_enable_o == $past(pins_s.tx_on))
        else $error("Transmit enable does not follow its pin");

    sleep_follow_a: assert property (!pins_s.sleep_n |=> sleep_mode_o)
        else $error("Sleep low did not enter sleep mode");

    count_cap_a: assert property (bit_cnt <= sgl_pkg::BIT_CNT_MAX)
        else $error("Bit count exceeded eight");

    sequence s_ready_pulse;
        pready_o ##1 !pready_o;
    endsequence

    ready_pulse_a: assert property (apb_setup |=> s_ready_pulse)
        else $error("Ready is not a single cycle pulse");

    unmapped_err_a: assert property (apb_setup && next_err |=> pslverr_o && pready_o)
        else $error("Unmapped address gave no error");

    idle_rdata_a: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
        else $error("Read data outside the access cycle");

    update_pulse_a: assert property (gain_update_o |=> !gain_update_o)
        else $error("Gain update longer than one cycle");

    gated_apply_a: assert property (win_rise && !load_en |=> !gain_update_o)
        else $error("Word applied while loading is disabled");

    slave_hold_a: assert property (!shifting |=> $stable(slave))
        else $error("Slave changed outside a load window");

    count_clear_a: assert property (win_fall |=> bit_cnt == 4'h0)
        else $error("Bit count not cleared at window fall");

    sleep_exit_a: assert property (pins_s.sleep_n |=> !sleep_mode_o)
        else $error("Sleep high did not give normal operation");

endmodule : sgl_serial_gain_loader

// ==== hdl/sgl_sync.sv ====
`timescale 1ns/1ps
module sgl_sync #(
    parameter int W = 5
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end

endmodule : sgl_sync
